// ### src/dss_regs.vh
/*
  constants for the dual-slope conversion sequencer: switch control codes,
  state codes and phase timing defaults.
  assumes inclusion by bare name from src/ design files.
*/
`ifndef DSS_REGS_VH
`define DSS_REGS_VH

// ***************************************************************
// switch control codes {ctl_a, ctl_b}
// ***************************************************************
`define DSS_SW_NULL 2'h0
`define DSS_SW_INPUT 2'h3
`define DSS_SW_REF 2'h1

// ***************************************************************
// sequencer states
// ***************************************************************
`define DSS_ST_IDLE 2'h0
`define DSS_ST_NULL 2'h1
`define DSS_ST_INPUT 2'h2
`define DSS_ST_REF 2'h3

// ***************************************************************
// timing defaults, in clock cycles at 250 MHz
// ***************************************************************
`define DSS_CLK_MHZ 250
// offset null phase: 20 ms
`define DSS_NULL_US 20000
// input integration: 16.6 ms minimum integration time
`define DSS_INPUT_US 16600
`define DSS_NULL_CYC (`DSS_NULL_US * `DSS_CLK_MHZ)
`define DSS_INPUT_CYC (`DSS_INPUT_US * `DSS_CLK_MHZ)
// de-integration limit: twice the input phase
`define DSS_REF_MAX_CYC (2 * `DSS_INPUT_CYC)
`define DSS_CNT_W 32
`define DSS_RES_W 24

`endif

// ### src/dss_sync2.v
/*
  two flip-flop synchroniser for one level input.
  assumes a single clock domain and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dss_sync2 (
  input wire mclk_i,
  input wire rst_n_i,
  input wire d_i,
  output reg q_o
);
  reg meta_r;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### src/dss_sequencer.v
/*
  dual-slope conversion sequencer: drives the two switch-control lines of
  an analog front end, watches its comparator and times the phases.
  assumes one 250 MHz clock; comparator arrives asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dss_regs.vh"
module dss_sequencer #(
  parameter [`DSS_CNT_W-1:0] NULL_CYC = `DSS_NULL_CYC,
  parameter [`DSS_CNT_W-1:0] INPUT_CYC = `DSS_INPUT_CYC,
  parameter [`DSS_CNT_W-1:0] REF_MAX_CYC = `DSS_REF_MAX_CYC,
  parameter RES_W = `DSS_RES_W
) (
  input wire mclk_i,
  input wire rst_n_i,
  input wire start_i,
  input wire continuous_i,
  input wire comp_i,
  output reg ctl_a_o,
  output reg ctl_b_o,
  output reg busy_o,
  output reg done_o,
  output reg overrange_o,
  output reg [RES_W-1:0] result_o,
  output reg [`DSS_CNT_W-1:0] input_count_o
);
  // ***************************************************************
  // input synchronisation
  // ***************************************************************
  wire comp_s;

  dss_sync2 u_comp_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(comp_i),
    .q_o(comp_s)
  );

  // ***************************************************************
  // phase sequencer
  // ***************************************************************
  // binary state codes
  localparam [1:0] ST_IDLE = `DSS_ST_IDLE;
  localparam [1:0] ST_NULL = `DSS_ST_NULL;
  localparam [1:0] ST_INPUT = `DSS_ST_INPUT;
  localparam [1:0] ST_REF = `DSS_ST_REF;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  // each phase up to about 17 s fits this count
  reg [`DSS_CNT_W-1:0] cnt_r;
  reg [`DSS_CNT_W-1:0] cnt_nxt;
  reg pending_r;
  reg pending_nxt;
  reg [`DSS_CNT_W-1:0] limit_cyc;
  wire at_limit;
  wire trip;
  wire want_next;
  wire end_ref;

  // comparator only looked at in de-integration; its null oscillation is noise
  assign trip = (state_r == ST_REF) && comp_s;

  // ***************************************************************
  // phase limits
  // ***************************************************************
  // count starts at zero, so limit is one below the phase length;
  // a zero length would wrap, so keep all three nonzero
  always @* begin
    case (state_r)
      ST_NULL: limit_cyc = NULL_CYC - 1'b1;
      ST_INPUT: limit_cyc = INPUT_CYC - 1'b1;
      ST_REF: limit_cyc = REF_MAX_CYC - 1'b1;
      default: limit_cyc = {`DSS_CNT_W{1'b0}};
    endcase
  end

  assign at_limit = (cnt_r >= limit_cyc);
  // another conversion wanted: free-running or a start seen
  assign want_next = continuous_i || pending_r || start_i;
  // de-integration over, by trip or by timeout
  assign end_ref = (state_r == ST_REF) && (trip || at_limit);

  // ***************************************************************
  // next state
  // ***************************************************************
  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1;
    pending_nxt = pending_r | start_i;
    case (state_r)
      ST_IDLE: begin
        cnt_nxt = {`DSS_CNT_W{1'b0}};
        if (want_next) begin
          state_nxt = ST_NULL;
          pending_nxt = 1'b0;
        end
      end
      ST_NULL: begin
        // offset_null_phase
        if (at_limit) begin
          state_nxt = ST_INPUT;
          cnt_nxt = {`DSS_CNT_W{1'b0}};
        end
      end
      ST_INPUT: begin
        // input_integrate_phase
        if (at_limit) begin
          state_nxt = ST_REF;
          cnt_nxt = {`DSS_CNT_W{1'b0}};
        end
      end
      ST_REF: begin
        // reference_deintegrate_phase
        if (end_ref) begin
          state_nxt = want_next ? ST_NULL : ST_IDLE;
          pending_nxt = 1'b0;
          cnt_nxt = {`DSS_CNT_W{1'b0}};
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt = {`DSS_CNT_W{1'b0}};
      end
    endcase
  end

  // ***************************************************************
  // state registers
  // ***************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= {`DSS_CNT_W{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // a start seen while busy waits here for the next null phase
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= pending_nxt;
    end
  end

  // ***************************************************************
  // switch controls
  // ***************************************************************
  // decoded from the next state, so controls move with the phase
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_a_o <= 1'b0;
      ctl_b_o <= 1'b0;
    end else begin
      case (state_nxt)
        ST_INPUT: {ctl_a_o, ctl_b_o} <= `DSS_SW_INPUT;
        ST_REF: {ctl_a_o, ctl_b_o} <= `DSS_SW_REF;
        default: {ctl_a_o, ctl_b_o} <= `DSS_SW_NULL;
      endcase
    end
  end

  // ***************************************************************
  // status
  // ***************************************************************
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      busy_o <= (state_nxt != ST_IDLE);
      // one cycle pulse; result and overrange stand until the next
      done_o <= end_ref;
    end
  end

  // ***************************************************************
  // results
  // ***************************************************************
  // fixed input phase, so the de-integration count alone is the numerator;
  // result wraps if the limit needs more than RES_W bits
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      overrange_o <= 1'b0;
      result_o <= {RES_W{1'b0}};
      input_count_o <= {`DSS_CNT_W{1'b0}};
    end else begin
      input_count_o <= INPUT_CYC;
      if (end_ref) begin
        // inclusive of the trip cycle
        result_o <= cnt_r[RES_W-1:0] + 1'b1;
        overrange_o <= ~trip;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/dss_props.sv
/* sequencer port checks.
   assumes bind onto dss_sequencer */
`timescale 1ns/1ps
`default_nettype none
module dss_props #(
  parameter int INPUT_CYC = 16,
  parameter int REF_MAX_CYC = 40,
  parameter int RES_W = 24
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ctl_a_o,
  input wire logic ctl_b_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic overrange_o,
  input wire logic [RES_W-1:0] result_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  chk_ctl_legal: assert property (!(ctl_a_o && !ctl_b_o)) else $error("bad ctl");
  chk_idle_null: assert property (!busy_o |-> !ctl_b_o) else $error("idle ctl");
  chk_null_first: assert property ($rose(busy_o) |-> !ctl_a_o [*8]) else $error("null short");
  chk_null_after: assert property ($fell(ctl_b_o) |-> !ctl_a_o [*8]) else $error("renull");
  chk_input_len: assert property ($rose(ctl_a_o) |-> ##INPUT_CYC ($fell(ctl_a_o) && ctl_b_o))
    else $error("input len");
  chk_done_once: assert property (done_o |=> !done_o) else $error("done wide");
  chk_done_ref: assert property (done_o |-> $past(ctl_b_o)) else $error("early done");
  chk_done_end: assert property (done_o |-> ##[0:1] !ctl_b_o) else $error("no end");
  chk_ovr_count: assert property (done_o && overrange_o |-> result_o == REF_MAX_CYC)
    else $error("ovr res");
endmodule
`default_nettype wire

// ### tb/dss_front.sv
/* front end model: comparator from switch state.
   assumes ctl lines from the sequencer */
`timescale 1ns/1ps
`default_nettype none
module dss_front (
  input wire logic mclk_i,
  input wire logic ctl_a_i,
  input wire logic ctl_b_i,
  input wire logic [7:0] trip_i,
  output logic comp_o
);
  logic [7:0] cnt_r = 8'h00;
  logic tog_r = 1'b0;
  always @(posedge mclk_i) begin
    cnt_r <= (ctl_b_i && !ctl_a_i) ? cnt_r + 8'h01 : 8'h00;
    tog_r <= ~tog_r;
  end
  // null loop oscillates, so a naive sequencer trips early
  assign comp_o = !ctl_b_i ? tog_r : !ctl_a_i && cnt_r >= trip_i;
endmodule
`default_nettype wire

// ### tb/tb.sv
/* sequencer bench.
   assumes short phase parameters */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i = 0, rst_n_i = 0, start_i = 0, continuous_i = 0, comp_i;
  logic ctl_a_o, ctl_b_o, busy_o, done_o, overrange_o;
  logic [23:0] result_o;
  logic [31:0] input_count_o, r1;
  logic [7:0] trip = 8'h0a;
  int err_total = 0, check_count = 0;
  always #2 mclk_i = ~mclk_i;
  // short phases stand in for the slow conversion rates
  dss_sequencer #(.NULL_CYC(32'h0000_0008), .INPUT_CYC(32'h0000_0010), .REF_MAX_CYC(32'h0000_0028))
    u_dss_sequencer (.mclk_i, .rst_n_i, .start_i, .continuous_i, .comp_i, .ctl_a_o, .ctl_b_o,
    .busy_o, .done_o, .overrange_o, .result_o, .input_count_o);
  dss_front u_dss_front (.mclk_i, .ctl_a_i(ctl_a_o), .ctl_b_i(ctl_b_o), .trip_i(trip), .comp_o(comp_i));
  task automatic chk(string n, logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic waitd;
    int i;
    @(negedge mclk_i);
    for (i = 0; i < 200 && done_o !== 1'b1; i++) @(negedge mclk_i);
    if (i == 200) begin
      chk("done", done_o, 32'h0000_0001);
      conclude;
    end
  endtask
  task automatic run(logic [7:0] t);
    @(posedge mclk_i) trip <= t;
    start_i <= 1'b1;
    @(posedge mclk_i) start_i <= 1'b0;
    waitd;
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic sc_ratio;
    run(8'h0a);
    r1 = result_o;
    chk("ovr", overrange_o, 32'h0000_0000);
    chk("res", result_o, 32'h0000_000d);
    chk("ctl", {ctl_a_o, ctl_b_o}, 32'h0000_0000);
    run(8'h14);
    chk("delta", result_o - r1, 32'h0000_000a);
    chk("in_cnt", input_count_o, 32'h0000_0010);
  endtask
  task automatic sc_reset;
    @(posedge mclk_i) start_i <= 1'b1;
    @(posedge mclk_i) start_i <= 1'b0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b0;
    @(negedge mclk_i);
    chk("rst", {ctl_a_o, ctl_b_o, busy_o, done_o}, 32'h0000_0000);
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    run(8'h0a);
    chk("rst_res", result_o, 32'h0000_000d);
  endtask
  task automatic sc_timeout;
    run(8'h3c);
    chk("ovr", overrange_o, 32'h0000_0001);
    chk("res", result_o, 32'h0000_0028);
  endtask
  task automatic sc_cont;
    @(posedge mclk_i) continuous_i <= 1'b1;
    run(8'h0c);
    chk("cont1", result_o, 32'h0000_000f);
    waitd;
    chk("cont", result_o, 32'h0000_000f);
    chk("busy", busy_o, 32'h0000_0001);
    @(posedge mclk_i) continuous_i <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    sc_ratio;
    sc_timeout;
    sc_reset;
    sc_cont;
    conclude;
  end
endmodule
bind dss_sequencer dss_props #(.INPUT_CYC(INPUT_CYC), .REF_MAX_CYC(REF_MAX_CYC), .RES_W(RES_W))
  u_dss_props (.mclk_i, .rst_n_i, .ctl_a_o, .ctl_b_o, .busy_o, .done_o, .overrange_o, .result_o);
`default_nettype wire
